// *** switch_on_fault_pkg.sv ***
// constants and carrier types for the switch-on-to-fault block
package switch_on_fault_pkg;
  localparam int CLK_HZ = 250000000;
  localparam int TICK_NS = 1000000;
  localparam int CLK_NS = 4;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam logic [20:0] RELEASE_MS_DEFAULT = 21'h0003E8;
  localparam int GROUPS = 8;
  localparam int LOG_DEPTH = 12;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam int MODE_W = 3;
  localparam logic [2:0] MODE_ON = 3'h0;
  localparam logic [2:0] MODE_BLOCKED = 3'h1;
  localparam logic [2:0] MODE_TEST = 3'h2;
  localparam logic [2:0] MODE_TEST_BLOCKED = 3'h3;
  localparam logic [2:0] MODE_OFF = 3'h4;
  localparam logic [1:0] FORCE_NORMAL = 2'h0;
  localparam logic [1:0] FORCE_BLOCKED = 2'h1;
  localparam logic [1:0] FORCE_ACTIVE = 2'h2;
  localparam logic [1:0] FORCE_TRIP = 2'h3;
  localparam logic [2:0] COND_NORMAL = 3'h0;
  localparam logic [2:0] COND_INIT = 3'h1;
  localparam logic [2:0] COND_ACTIVE = 3'h2;
  localparam logic [2:0] COND_TRIP = 3'h3;
  localparam logic [2:0] COND_BLOCKED = 3'h4;
  localparam int EV_INIT = 0;
  localparam int EV_BLOCK = 1;
  localparam int EV_ACTIVE = 2;
  localparam int EV_TRIP = 3;

  typedef struct packed {
    logic [3:0] on;
    logic [3:0] off;
  } event_flags_t;

  typedef struct packed {
    logic [47:0] stamp;
    logic [1:0] event_code;
    logic [2:0] group;
    logic [20:0] remaining_ms;
    logic [20:0] active_ms;
  } log_record_t;
endpackage

// *** switch_on_fault.sv ***
// switch-on-to-fault arming, trip, events, counters and record log
`timescale 1ns/1ps
// Notes on behaviour
// R1 - arm only on rising edge of activate
// R2 - window lasts selected release time, ms steps
// R3 - function input during window trips immediately
// R4 - block input stops arming, reports blocked
// R5 - activate comes from input or close command; the block takes activate_in only, which the bench drives from close_cmd
// R6 - five node modes, on default, reported
// R7 - forcing overrides reported state when enabled
// R8 - condition status shows one of five states
// R9 - on/off events per condition, maskable
// R10 - cumulative counters per condition, clearable
// R11 - log last twelve activation records
// R12 - release time follows live setting group
// R13 - expiry without trip returns to normal
module switch_on_fault (
  input wire logic clk,
  input wire logic reset,
  input wire logic activate_in,
  input wire logic block_in,
  input wire logic [7:0] function_in,
  input wire logic [2:0] node_operating_mode,
  input wire logic force_enable,
  input wire logic [1:0] force_select,
  input wire logic [2:0] group_select,
  input wire logic [switch_on_fault_pkg::GROUPS*21-1:0] release_ms_table,
  input wire logic [47:0] time_stamp,
  input wire logic [3:0] event_on_mask,
  input wire logic [3:0] event_off_mask,
  input wire logic counter_clear,
  input wire logic [3:0] log_read_index,
  output logic trip_out,
  output logic active_out,
  output logic [2:0] condition_status,
  output logic [2:0] node_mode_in_effect,
  output switch_on_fault_pkg::event_flags_t event_pulse,
  output logic [63:0] event_counts,
  output switch_on_fault_pkg::log_record_t log_data,
  output logic [3:0] log_count
);
  logic [2:0] act_sync, blk_sync;
  logic [7:0] fn_sync [3];
  logic act_level_reg, act_level_next;
  logic blk_level_reg, blk_level_next;
  logic [7:0] fn_level_reg, fn_level_next;
  logic act_prev_reg, act_prev_next;
  logic [17:0] tick_cnt_reg, tick_cnt_next;
  logic [20:0] elapsed_reg, elapsed_next;
  logic armed_reg, armed_next;
  logic trip_reg, trip_next;
  logic [3:0] cond_reg;
  logic [3:0] cond_prev_reg;
  logic [3:0] cond_now;
  logic [20:0] release_ms;
  logic arm_edge, mode_blocks, mode_off, tick;
  logic [15:0] count_reg [4];
  logic [15:0] count_next [4];
  switch_on_fault_pkg::log_record_t log_mem [switch_on_fault_pkg::LOG_DEPTH];
  logic [3:0] wr_ptr_reg;
  logic [3:0] log_cnt_reg;
  logic [2:0] status_next;

  // three-stage capture of pin inputs, qualified on stages two and three
  always_ff @(posedge clk) begin
    act_sync <= {act_sync[1:0], activate_in};
    blk_sync <= {blk_sync[1:0], block_in};
    fn_sync[0] <= function_in;
    fn_sync[1] <= fn_sync[0];
    fn_sync[2] <= fn_sync[1];
  end

  always_comb begin
    act_level_next = (act_sync[1] == act_sync[2]) ? act_sync[2] : act_level_reg;
    blk_level_next = (blk_sync[1] == blk_sync[2]) ? blk_sync[2] : blk_level_reg;
    for (int i = 0; i < 8; i++) begin
      fn_level_next[i] = (fn_sync[1][i] == fn_sync[2][i]) ?
                         fn_sync[2][i] : fn_level_reg[i];
    end
  end

  always_comb begin
    release_ms = release_ms_table[group_select*21 +: 21]; // R12
    mode_off = (node_operating_mode == switch_on_fault_pkg::MODE_OFF);
    mode_blocks =
        (node_operating_mode == switch_on_fault_pkg::MODE_BLOCKED) ||
        (node_operating_mode == switch_on_fault_pkg::MODE_TEST_BLOCKED);
    arm_edge = act_level_reg && !act_prev_reg; // R1
    tick = (tick_cnt_reg == 18'(switch_on_fault_pkg::TICK_CYCLES - 1));
  end

  // timer and trip state
  always_comb begin
    act_prev_next = act_level_reg;
    tick_cnt_next = tick ? 18'h00000 : tick_cnt_reg + 18'h00001;
    armed_next = armed_reg;
    elapsed_next = elapsed_reg;
    trip_next = trip_reg;
    if (mode_off) begin
      armed_next = 1'b0;
      trip_next = 1'b0;
    end else if (arm_edge && !blk_level_reg && !mode_blocks) begin // R1 R4
      armed_next = 1'b1;
      elapsed_next = 21'h000000;
      tick_cnt_next = 18'h00000;
      // closing onto a standing fault trips at once
      trip_next = |fn_level_reg; // R3
    end else if (armed_reg) begin
      if (|fn_level_reg) begin
        trip_next = 1'b1; // R3
      end
      if (tick) begin
        elapsed_next = elapsed_reg + 21'h000001;
      end
      if (elapsed_reg >= release_ms) begin // R2 R12
        armed_next = 1'b0; // R13
        trip_next = 1'b0;
      end
    end else begin
      trip_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // level and previous start high: a level already up never arms
      act_level_reg <= 1'b1;
      blk_level_reg <= 1'b0;
      fn_level_reg <= 8'h00;
      act_prev_reg <= 1'b1;
      tick_cnt_reg <= 18'h00000;
      elapsed_reg <= 21'h000000;
      armed_reg <= 1'b0;
      trip_reg <= 1'b0;
    end else begin
      act_level_reg <= act_level_next;
      blk_level_reg <= blk_level_next;
      fn_level_reg <= fn_level_next;
      act_prev_reg <= act_prev_next;
      tick_cnt_reg <= tick_cnt_next;
      elapsed_reg <= elapsed_next;
      armed_reg <= armed_next;
      trip_reg <= trip_next;
    end
  end

  // condition vector: init is the arming edge, block covers input or mode
  always_comb begin
    cond_now[switch_on_fault_pkg::EV_INIT] = armed_next && !armed_reg;
    cond_now[switch_on_fault_pkg::EV_BLOCK] =
        (blk_level_reg || mode_blocks) && !mode_off; // R4
    cond_now[switch_on_fault_pkg::EV_ACTIVE] = armed_next;
    cond_now[switch_on_fault_pkg::EV_TRIP] = trip_next;
    status_next = cond_now[switch_on_fault_pkg::EV_BLOCK] ?
                  switch_on_fault_pkg::COND_BLOCKED :
                  switch_on_fault_pkg::COND_NORMAL; // R13
    if (armed_next) status_next = switch_on_fault_pkg::COND_ACTIVE;
    if (armed_next && !armed_reg) status_next = switch_on_fault_pkg::COND_INIT;
    if (trip_next) status_next = switch_on_fault_pkg::COND_TRIP; // R8
    if (force_enable) begin // R7
      case (force_select)
        switch_on_fault_pkg::FORCE_BLOCKED:
          status_next = switch_on_fault_pkg::COND_BLOCKED;
        switch_on_fault_pkg::FORCE_ACTIVE:
          status_next = switch_on_fault_pkg::COND_ACTIVE;
        switch_on_fault_pkg::FORCE_TRIP:
          status_next = switch_on_fault_pkg::COND_TRIP;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cond_reg <= 4'h0;
      cond_prev_reg <= 4'h0;
      condition_status <= switch_on_fault_pkg::COND_NORMAL;
      node_mode_in_effect <= switch_on_fault_pkg::MODE_ON;
      event_pulse <= '0;
      trip_out <= 1'b0;
      active_out <= 1'b0;
    end else begin
      cond_reg <= cond_now;
      cond_prev_reg <= cond_reg;
      condition_status <= status_next;
      node_mode_in_effect <= node_operating_mode; // R6
      event_pulse.on <= cond_reg & ~cond_prev_reg & event_on_mask; // R9
      event_pulse.off <= ~cond_reg & cond_prev_reg & event_off_mask; // R9
      trip_out <= trip_next || (force_enable &&
                  force_select == switch_on_fault_pkg::FORCE_TRIP); // R3 R7
      active_out <= armed_next;
    end
  end

  // counters; an ON edge in the clear cycle still counts
  for (genvar g = 0; g < 4; g++) begin : g_count
    always_comb begin
      count_next[g] = count_reg[g];
      if (cond_reg[g] && !cond_prev_reg[g]) begin
        count_next[g] = counter_clear ? 16'h0001 : count_reg[g] + 16'h0001;
      end else if (counter_clear) begin
        count_next[g] = switch_on_fault_pkg::COUNT_RESET; // R10
      end
    end
    always_ff @(posedge clk) begin
      if (reset) count_reg[g] <= switch_on_fault_pkg::COUNT_RESET;
      else count_reg[g] <= count_next[g];
    end
  end

  // one process owns the whole output word
  always_ff @(posedge clk) begin
    if (reset) event_counts <= {4{switch_on_fault_pkg::COUNT_RESET}};
    else event_counts <= {count_reg[3], count_reg[2],
                          count_reg[1], count_reg[0]};
  end

  // circular log, oldest overwritten once twelve are held
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_reg <= 4'h0;
      log_cnt_reg <= 4'h0;
    end else if (cond_now[switch_on_fault_pkg::EV_INIT]) begin // R11
      log_mem[wr_ptr_reg] <= '{time_stamp,
                                2'(switch_on_fault_pkg::EV_ACTIVE),
                                group_select, release_ms, 21'h000000};
      wr_ptr_reg <= (wr_ptr_reg == 4'(switch_on_fault_pkg::LOG_DEPTH - 1)) ?
                    4'h0 : wr_ptr_reg + 4'h1;
      if (log_cnt_reg != 4'(switch_on_fault_pkg::LOG_DEPTH)) begin
        log_cnt_reg <= log_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      log_data <= '0;
      log_count <= 4'h0;
    end else begin
      log_count <= log_cnt_reg;
      log_data <= (log_read_index < 4'(switch_on_fault_pkg::LOG_DEPTH)) ?
                  log_mem[log_read_index] : '0;
    end
  end

  sequence s_arm_request;
    arm_edge && !blk_level_reg && !mode_blocks && !mode_off;
  endsequence

  a_edge_arms: assert property (@(posedge clk) disable iff (reset) // R1
    s_arm_request |=> active_out) else $error("edge did not arm");
  a_trip_in_window: assert property (@(posedge clk) disable iff (reset) // R3
    armed_reg && (|fn_level_reg) && !mode_off && elapsed_reg < release_ms
    |=> trip_out) else $error("trip missing in window");
  a_no_rearm_level: assert property (@(posedge clk) disable iff (reset) // R1
    act_prev_reg && armed_reg == 1'b0 |=> !active_out || arm_edge)
    else $error("armed without edge");
  a_block_stops_arm: assert property (@(posedge clk) disable iff (reset) // R4
    !armed_reg && blk_level_reg |=> !active_out)
    else $error("armed while blocked");
  a_expiry_clears: assert property (@(posedge clk) disable iff (reset) // R13
    armed_reg && elapsed_reg >= release_ms && !arm_edge |=> !active_out)
    else $error("window outlived release");
  a_mode_reported: assert property (@(posedge clk) disable iff (reset) // R6
    1'b1 |=> node_mode_in_effect == $past(node_operating_mode))
    else $error("mode not reported");
  a_force_trip: assert property (@(posedge clk) disable iff (reset) // R7
    force_enable && force_select == switch_on_fault_pkg::FORCE_TRIP |=>
    condition_status == switch_on_fault_pkg::COND_TRIP)
    else $error("force ignored");
  a_status_legal: assert property (@(posedge clk) disable iff (reset) // R8
    condition_status <= switch_on_fault_pkg::COND_BLOCKED)
    else $error("bad status");
  a_on_event_masked: assert property (@(posedge clk) disable iff (reset) // R9
    cond_reg[switch_on_fault_pkg::EV_TRIP] &&
    !cond_prev_reg[switch_on_fault_pkg::EV_TRIP] &&
    event_on_mask[switch_on_fault_pkg::EV_TRIP]
    |=> event_pulse.on[switch_on_fault_pkg::EV_TRIP])
    else $error("trip on event lost");
  a_counter_clear: assert property (@(posedge clk) disable iff (reset) // R10
    counter_clear && !(cond_reg[0] && !cond_prev_reg[0])
    |=> ##1 event_counts[15:0] == 16'h0000) else $error("clear failed");
  a_log_bounded: assert property (@(posedge clk) disable iff (reset) // R11
    log_cnt_reg <= 4'(switch_on_fault_pkg::LOG_DEPTH))
    else $error("log overflow");
endmodule // switch_on_fault

// *** close_source.sv ***
// breaker close command and protection start source for the bench
`timescale 1ns/1ps
module close_source #(
  parameter int CLOSE_DELAY = 2
) (
  input wire logic clk,
  input wire logic close_cmd,
  input wire logic [7:0] start_cmd,
  output logic activate,
  output logic [7:0] starts
);
  logic [7:0] pipe_reg;
  always_ff @(posedge clk) begin
    pipe_reg <= {pipe_reg[6:0], close_cmd};
    // breaker position follows the command after contact travel
    activate <= pipe_reg[CLOSE_DELAY-1];
    starts <= start_cmd;
  end
endmodule // close_source

// *** tb_top.sv ***
// self-checking bench for the switch-on-to-fault block
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, a, e); end end
module tb_top;
  logic clk, reset, close_cmd, block_in, force_enable, counter_clear;
  logic activate, trip_out, active_out, clr_seen;
  logic [7:0] start_cmd, starts;
  logic [2:0] mode, group_select, condition_status, mode_eff;
  logic [1:0] force_select;
  logic [167:0] table_ms;
  logic [3:0] log_count, off_mask;
  logic [63:0] cnt;
  switch_on_fault_pkg::event_flags_t ev, seen;
  switch_on_fault_pkg::log_record_t rec;
  int n_mismatch = 0;
  int compares = 0;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // sticky copy of one-cycle event pulses
  always @(posedge clk) seen <= (reset || clr_seen) ? '0 : seen | ev;
  close_source i_close_source (.clk(clk), .close_cmd(close_cmd),
    .start_cmd(start_cmd), .activate(activate), .starts(starts));
  switch_on_fault i_switch_on_fault (.clk(clk), .reset(reset),
    .activate_in(activate), .block_in(block_in), .function_in(starts),
    .node_operating_mode(mode), .force_enable(force_enable),
    .force_select(force_select), .group_select(group_select),
    .release_ms_table(table_ms), .time_stamp(48'h000000001234),
    .event_on_mask(4'hF), .event_off_mask(off_mask),
    .counter_clear(counter_clear), .log_read_index(4'h0),
    .trip_out(trip_out), .active_out(active_out),
    .condition_status(condition_status), .node_mode_in_effect(mode_eff),
    .event_pulse(ev), .event_counts(cnt), .log_data(rec),
    .log_count(log_count));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_mode;
    for (int m = 4; m >= 0; m--) begin
      mode = 3'(m);
      cyc(4);
      `CHK(mode_eff, 3'(m))
    end
    $display("test mode done");
  endtask
  task automatic t_force;
    logic [2:0] exp [4] = '{3'h0, 3'h4, 3'h2, 3'h3};
    force_enable = 1'b1;
    for (int f = 0; f < 4; f++) begin
      force_select = 2'(f);
      cyc(4);
      `CHK(condition_status, exp[f])
    end
    force_enable = 1'b0;
    force_select = 2'h0;
    cyc(4);
    `CHK(condition_status, 3'h0)
    $display("test force done");
  endtask
  task automatic t_block;
    block_in = 1'b1;
    cyc(8);
    close_cmd = 1'b1;
    cyc(20);
    `CHK(active_out, 1'b0)
    `CHK(condition_status, 3'h4)
    // blocked and test-blocked modes earlier count as blocked too
    `CHK(cnt[31:0], 32'h00030000)
    clr_seen = 1'b1;
    cyc(1);
    clr_seen = 1'b0;
    block_in = 1'b0;
    close_cmd = 1'b0;
    cyc(12);
    `CHK(seen.off, 4'h0)
    $display("test block done");
  endtask
  task automatic t_arm;
    int i;
    close_cmd = 1'b1;
    for (i = 0; i < 30 && active_out !== 1'b1; i++) cyc(1);
    `CHK(active_out, 1'b1)
    cyc(4);
    `CHK(condition_status, 3'h2)
    `CHK(trip_out, 1'b0)
    start_cmd = 8'h80;
    for (i = 0; i < 20 && trip_out !== 1'b1; i++) cyc(1);
    `CHK(trip_out, 1'b1)
    cyc(4);
    `CHK(condition_status, 3'h3)
    `CHK(seen.on, 4'hD)
    `CHK(cnt, 64'h0001000100030001)
    `CHK(log_count, 4'h1)
    `CHK(rec.group, 3'h5)
    `CHK(rec.remaining_ms, 21'h000006)
    `CHK(rec.active_ms, 21'h000000)
    `CHK(rec.stamp, 48'h000000001234)
    start_cmd = 8'h00;
    cyc(40);
    `CHK(cnt[15:0], 16'h0001)
    `CHK(active_out, 1'b1)
    off_mask = 4'hF;
    group_select = 3'h0;
    cyc(6);
    `CHK(active_out, 1'b0)
    `CHK(trip_out, 1'b0)
    `CHK(condition_status, 3'h0)
    `CHK(seen.off, 4'hC)
    $display("test arm done");
  endtask
  task automatic t_clear_off;
    close_cmd = 1'b0;
    group_select = 3'h5;
    cyc(10);
    close_cmd = 1'b1;
    start_cmd = 8'h01;
    cyc(16);
    `CHK(trip_out, 1'b1)
    `CHK(log_count, 4'h2)
    mode = 3'h4;
    cyc(4);
    `CHK(trip_out, 1'b0)
    `CHK(active_out, 1'b0)
    start_cmd = 8'h00;
    counter_clear = 1'b1;
    cyc(1);
    counter_clear = 1'b0;
    cyc(4);
    `CHK(cnt, 64'h0000000000000000)
    $display("test clear and off done");
  endtask
  task automatic wrap_up;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    {close_cmd, block_in, force_enable, counter_clear, clr_seen} = '0;
    start_cmd = 8'h00;
    mode = 3'h0;
    force_select = 2'h0;
    group_select = 3'h5;
    for (int g = 0; g < 8; g++) table_ms[g*21 +: 21] = 21'(g + 1);
    // group 0 has zero release: switching to it ends a running window
    table_ms[20:0] = 21'h000000;
    off_mask = 4'h0;
    cyc(8);
    reset = 1'b0;
    cyc(2);
    t_mode;
    t_force;
    t_block;
    t_arm;
    t_clear_off;
    wrap_up;
  end
  // the tests need well under 1000 cycles
  initial begin
    #100000;
    n_mismatch++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    wrap_up;
  end
endmodule // tb_top
